// *** src/power_monitor_serial_slave.sv ***
`timescale 1ns/10ps
// ========================================
// Summary of operation
// - Device is target only; master starts transfers and drives the clock.
// - Every read and write carries two data bytes, upper byte first.
// - Data changes only while clock low; changes with clock high are start/stop.
// - Data line driver released after power-up until a transfer needs it.
// - Bus ignored until a start: data falls while clock high.
// - Starts during the power-up sequence are ignored.
// - Master ends with stop (data rises, clock high); device returns to standby.
// - Address is 1 then three 2-bit strap codes for pins 2, 1, 0.
// - 55 straps usable; pin 2 on clock with pin 1 on data/clock reserved.
// - Pin 2 on data, pin 1 ground, pin 0 supply is reserved.
// - Eighth address bit: 1 means read, 0 means write.
// - Acknowledge the address byte only when it matches the strapped address.
// - Pointer cleared to zero at reset; current-address read starts there.
// - Write: address, pointer, upper, lower bytes each acknowledged; standby only at the stop.
// - Read: address, pointer, repeated start, read address acknowledged, then data.
// - Second byte sent only if first acknowledged; master then nacks and stops.
// - Pointer loads from the pointer byte, then advances per two-byte word.
// - Only the first write before a stop is held and applied at the stop; later words are dropped.
// - Master code 0000 1xxx enters fast mode; stop ends it, repeated start keeps it.
module power_monitor_serial_slave
    import pm_serial_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [1:0] addr_strap_pin_0,
    input  wire logic [1:0] addr_strap_pin_1,
    input  wire logic [1:0] addr_strap_pin_2,
    output logic            reg_wr_valid,
    input  wire logic       reg_wr_ready,
    output reg_write_t      reg_wr,
    output reg_read_req_t   reg_rd_req,
    input  wire logic [15:0] reg_rd_data,
    output logic            addr_reserved,
    output logic            fast_mode,
    output logic            busy
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } state_t;

    // ========================================
    // Input synchronisers and glitch filters
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [2:0] scl_cnt_r;
    logic [2:0] sda_cnt_r;
    logic       scl_f_r;
    logic       sda_f_r;
    logic       scl_d_r;
    logic       sda_d_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
        end
    end

    // Level must be stable FILTER_CYCLES before it is accepted
    wire scl_differs = scl_sync_r[1] != scl_f_r;
    wire sda_differs = sda_sync_r[1] != sda_f_r;
    wire scl_accept  = scl_differs && (scl_cnt_r == FILTER_CNT_MAX);
    wire sda_accept  = sda_differs && (sda_cnt_r == FILTER_CNT_MAX);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_cnt_r <= 3'h0;
            sda_cnt_r <= 3'h0;
            scl_f_r   <= 1'b1;
            sda_f_r   <= 1'b1;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
        end else begin
            scl_cnt_r <= (scl_differs && !scl_accept) ? scl_cnt_r + 3'h1 : 3'h0;
            sda_cnt_r <= (sda_differs && !sda_accept) ? sda_cnt_r + 3'h1 : 3'h0;
            if (scl_accept) scl_f_r <= scl_sync_r[1];
            if (sda_accept) sda_f_r <= sda_sync_r[1];
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
        end
    end

    wire scl_rise  = scl_f_r && !scl_d_r;
    wire scl_fall  = !scl_f_r && scl_d_r;
    wire start_det = scl_f_r && scl_d_r && !sda_f_r && sda_d_r;
    wire stop_det  = scl_f_r && scl_d_r && sda_f_r && !sda_d_r;

    // ========================================
    // Power-up hold-off
    logic [6:0] pwr_cnt_r;
    wire        pwr_done = (pwr_cnt_r == POWERUP_CNT_MAX);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) pwr_cnt_r <= 7'h00;
        else if (!pwr_done) pwr_cnt_r <= pwr_cnt_r + 7'h01;
    end

    // ========================================
    // Strapped address, captured after reset release
    logic [6:0] own_addr_r;
    logic       reserved_r;
    wire  [1:0] p2 = addr_strap_pin_2;
    wire  [1:0] p1 = addr_strap_pin_1;
    wire  [1:0] p0 = addr_strap_pin_0;
    wire        strap_rsv_a = (p2 == STRAP_CLOCK) && (p1 == STRAP_DATA || p1 == STRAP_CLOCK);
    wire        strap_rsv_b = (p2 == STRAP_DATA) && (p1 == STRAP_GND) && (p0 == STRAP_SUPPLY);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            own_addr_r <= 7'h00;
            reserved_r <= 1'b1;
        end else if (!pwr_done) begin
            own_addr_r <= {ADDR_LEAD_BIT, p2, p1, p0};
            reserved_r <= strap_rsv_a || strap_rsv_b;
        end
    end

    // ========================================
    // Protocol engine
    state_t      state_r, state_nxt;
    logic [2:0]  bit_r;
    logic [7:0]  shift_r;
    logic [7:0]  ptr_r;
    logic        byte_idx_r;
    logic [7:0]  wr_hi_r;
    logic        sda_oe_r;
    logic        dir_r;
    logic        fast_r;
    logic        mcode_r;
    reg_write_t  pend_r;
    logic        pend_valid_r;
    logic [15:0] rd_word_r;

    wire [7:0] rx_byte   = {shift_r[6:0], sda_f_r};
    wire       byte_done = scl_rise && (bit_r == BITCNT_LAST);
    wire       addr_hit  = (rx_byte[7:1] == own_addr_r) && !reserved_r;
    wire       hs_code   = (rx_byte[7:3] == HS_CODE_TOP);
    wire       word_done = byte_done && byte_idx_r;
    wire       buf_ready;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:      state_nxt = ST_IDLE;
            ST_ADDR:      if (byte_done) state_nxt = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
            // Ack is driven at the first fall and must stand until the second one
            ST_ADDR_ACK:  if (scl_fall && sda_oe_r) state_nxt = (dir_r == DIR_READ) ? ST_RDATA : ST_PTR;
            ST_PTR:       if (byte_done) state_nxt = ST_PTR_ACK;
            ST_PTR_ACK:   if (scl_fall && sda_oe_r) state_nxt = ST_WDATA;
            ST_WDATA:     if (byte_done) state_nxt = ST_WDATA_ACK;
            ST_WDATA_ACK: if (scl_fall && sda_oe_r) state_nxt = ST_WDATA;
            ST_RDATA:     if (scl_fall && bit_r == 3'h0 && sda_oe_r == 1'b0 && byte_idx_r) state_nxt = ST_RDATA;
            ST_RDATA_ACK: if (scl_rise) state_nxt = (sda_f_r || byte_idx_r) ? ST_IGNORE : ST_RDATA;
            ST_IGNORE:    state_nxt = ST_IGNORE;
            default:      state_nxt = ST_IDLE;
        endcase
        if (state_r == ST_RDATA && byte_done) state_nxt = ST_RDATA_ACK;
        if (start_det && pwr_done) state_nxt = ST_ADDR;
        if (stop_det) state_nxt = ST_IDLE;
    end

    // Data line: pull low on ack slots and on read bits that are 0, release otherwise
    wire ack_slot  = (state_r == ST_ADDR_ACK) || (state_r == ST_PTR_ACK) || (state_r == ST_WDATA_ACK);
    // A read bit goes out on the fall before bit_r counts it, so index the coming bit
    wire [2:0] rd_idx = (state_r == ST_RDATA) ? bit_r + 3'h1 : 3'h0;
    wire rd_bit    = rd_word_r[byte_idx_r ? {1'b0, ~rd_idx} : {1'b1, ~rd_idx}];
    wire entering  = state_nxt != state_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (start_det || stop_det) sda_oe_r <= 1'b0;
            else if (scl_fall) sda_oe_r <= (state_nxt == ST_ADDR_ACK || state_nxt == ST_PTR_ACK ||
                                             state_nxt == ST_WDATA_ACK) ? 1'b1 :
                                            (state_nxt == ST_RDATA) ? !rd_bit : 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            byte_idx_r <= 1'b0;
            dir_r <= DIR_WRITE;
        end else begin
            if (start_det || (entering && scl_fall)) bit_r <= 3'h0;
            // Count holds at 7 over the master's ack so the next byte starts at 0
            else if ((state_r == ST_RDATA ? scl_fall : scl_rise) && !ack_slot && (state_r != ST_RDATA_ACK))
                bit_r <= bit_r + 3'h1;
            if (scl_rise) shift_r <= rx_byte;
            if (start_det || (state_r == ST_ADDR_ACK && scl_fall)) byte_idx_r <= 1'b0;
            else if ((state_r == ST_WDATA_ACK || state_r == ST_RDATA_ACK) && entering) byte_idx_r <= ~byte_idx_r;
            if (state_r == ST_ADDR && byte_done) dir_r <= rx_byte[0];
        end
    end

    // Pointer, staged write and fast mode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ptr_r <= POINTER_RESET;
            wr_hi_r <= 8'h00;
            pend_r <= '0;
            pend_valid_r <= 1'b0;
            fast_r <= 1'b0;
            mcode_r <= 1'b0;
        end else begin
            if (state_r == ST_PTR && byte_done) ptr_r <= rx_byte;
            else if (state_r == ST_WDATA && word_done) ptr_r <= ptr_r + 8'h01;
            else if (state_r == ST_RDATA_ACK && scl_rise && byte_idx_r) ptr_r <= ptr_r + 8'h01;
            if (state_r == ST_WDATA && byte_done && !byte_idx_r) wr_hi_r <= rx_byte;
            if (state_r == ST_WDATA && word_done && !pend_valid_r) begin
                pend_r <= '{addr: ptr_r, data: {wr_hi_r, rx_byte}};
                pend_valid_r <= 1'b1;
            end
            if (stop_det && pend_valid_r && buf_ready) pend_valid_r <= 1'b0;
            if (state_r == ST_ADDR && byte_done && hs_code) mcode_r <= 1'b1;
            if (mcode_r && start_det) fast_r <= 1'b1;
            if (stop_det) begin
                fast_r <= 1'b0;
                mcode_r <= 1'b0;
            end
        end
    end

    // Read word latched when the read phase begins and again during each master acknowledge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) rd_word_r <= 16'h0000;
        else if ((state_r == ST_ADDR_ACK && dir_r == DIR_READ) || state_r == ST_RDATA_ACK) rd_word_r <= reg_rd_data;
    end

    // ========================================
    // Completed writes queue here, two deep; in a long core stall one more is held pending and later words are lost
    reg_write_t buf_out;
    logic       buf_valid;

    pm_write_buffer u_wbuf (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (stop_det && pend_valid_r),
        .in_ready  (buf_ready),
        .in_data   (pend_r),
        .out_valid (buf_valid),
        .out_ready (reg_wr_ready && !reg_wr_valid),
        .out_data  (buf_out)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_wr_valid <= 1'b0;
            reg_wr <= '0;
            reg_rd_req <= '0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            addr_reserved <= 1'b0;
            fast_mode <= 1'b0;
            busy <= 1'b0;
        end else begin
            reg_wr_valid <= buf_valid && reg_wr_ready && !reg_wr_valid;
            if (buf_valid && reg_wr_ready && !reg_wr_valid) reg_wr <= buf_out;
            reg_rd_req <= '{addr: ptr_r};
            sda_oe <= sda_oe_r;
            addr_reserved <= reserved_r;
            fast_mode <= fast_r;
            busy <= (state_r != ST_IDLE) && (state_r != ST_IGNORE);
        end
    end

    // ========================================
    // Checks
    a_ack_needs_match: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r == ST_ADDR && byte_done && !addr_hit && !start_det && !stop_det) |=> state_r == ST_IGNORE)
        else $error("mismatched address was acknowledged");
    a_stop_releases: assert property (@(posedge clock) disable iff (!rst_b)
        stop_det |=> (state_r == ST_IDLE && !sda_oe_r) ##1 !sda_oe)
        else $error("stop did not release bus");
    a_powerup_ignore: assert property (@(posedge clock) disable iff (!rst_b)
        (!pwr_done && state_r == ST_IDLE) |=> state_r == ST_IDLE)
        else $error("start taken during power-up");
    a_start_restarts: assert property (@(posedge clock) disable iff (!rst_b)
        (start_det && pwr_done) |=> state_r == ST_ADDR && !sda_oe_r)
        else $error("start did not restart address phase");
    a_ptr_load: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r == ST_PTR && byte_done && !stop_det) |=> ptr_r == $past(rx_byte))
        else $error("pointer did not load");
    a_write_deferred: assert property (@(posedge clock) disable iff (!rst_b)
        (pend_valid_r && !stop_det) |=> pend_valid_r && (pend_r == $past(pend_r)))
        else $error("held write changed before stop");
    a_strap_reserved: assert property (@(posedge clock) disable iff (!rst_b)
        (pwr_done && strap_rsv_b && $stable(p2) && $stable(p1) && $stable(p0) && $past(!pwr_done)) |-> reserved_r)
        else $error("reserved strap not flagged");
    a_dir_capture: assert property (@(posedge clock) disable iff (!rst_b)
        (state_r == ST_ADDR && byte_done && addr_hit && !start_det && !stop_det) |=> dir_r == $past(rx_byte[0]))
        else $error("direction bit not captured");

endmodule : power_monitor_serial_slave

// *** include/pm_serial_pkg.sv ***
package pm_serial_pkg;

    // ========================================
    // Address straps
    localparam logic [1:0] STRAP_GND        = 2'h0;
    localparam logic [1:0] STRAP_SUPPLY     = 2'h1;
    localparam logic [1:0] STRAP_DATA       = 2'h2;
    localparam logic [1:0] STRAP_CLOCK      = 2'h3;
    localparam logic       ADDR_LEAD_BIT    = 1'h1;

    // ========================================
    // Glitch filter and timing
    localparam int         CLK_HZ           = 50_000_000;
    localparam int         FILTER_NS        = 100;
    localparam int         FILTER_CYCLES    = (FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [2:0] FILTER_CNT_MAX   = 3'(FILTER_CYCLES - 1);
    localparam int         POWERUP_NS       = 1000;
    localparam int         POWERUP_CYCLES   = (POWERUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [6:0] POWERUP_CNT_MAX  = 7'(POWERUP_CYCLES);

    // ========================================
    // Reset value and protocol constants
    localparam logic [7:0] POINTER_RESET    = 8'h00;
    localparam logic [2:0] BITCNT_LAST      = 3'h7;
    localparam logic [4:0] HS_CODE_TOP      = 5'h01;

    typedef enum logic [0:0] {
        DIR_WRITE = 1'b0,
        DIR_READ  = 1'b1
    } dir_t;

    // Register write handed to the device core
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
    } reg_write_t;

    // Register read request to the device core
    typedef struct packed {
        logic [7:0]  addr;
    } reg_read_req_t;

endpackage : pm_serial_pkg

// *** src/pm_write_buffer.sv ***
`timescale 1ns/10ps
// ========================================
// Two-entry buffer for completed register writes
module pm_write_buffer
    import pm_serial_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire reg_write_t in_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output reg_write_t      out_data
);
    reg_write_t mem_r [2];
    logic       wr_ptr_r;
    logic       rd_ptr_r;
    logic [1:0] count_r;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) wr_ptr_r <= ~wr_ptr_r;
            if (pop) rd_ptr_r <= ~rd_ptr_r;
            count_r <= count_r + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (push) mem_r[wr_ptr_r] <= in_data;
    end

    a_buf_no_overflow: assert property (@(posedge clock) disable iff (!rst_b)
        count_r <= 2'h2) else $error("write buffer count above two");

endmodule : pm_write_buffer

// *** testbench/bus_master_model.sv ***
`timescale 1ns/10ps
// ========================================
// Bus master: owns the clock line, releases data high when not pulling
module bus_master_model #(
    parameter int PHASE = 8
) (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // Clock stands high between frames; a phase of 8 cycles clears the 5-cycle input filter
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_phase();
        repeat (PHASE) @(negedge clock);
    endtask : wait_phase

    // Also used as repeated start; the leading low phase lets the slave drop its acknowledge first
    task automatic start_cond();
        wait_phase();
        sda_drv = 1'b1;
        wait_phase();
        scl = 1'b1;
        wait_phase();
        sda_drv = 1'b0;
        wait_phase();
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_phase();
        sda_drv = 1'b0;
        wait_phase();
        scl = 1'b1;
        wait_phase();
        sda_drv = 1'b1;
        wait_phase();
    endtask : stop_cond

    task automatic clock_bit(input logic b, output logic seen);
        wait_phase();
        sda_drv = b;
        wait_phase();
        scl = 1'b1;
        wait_phase();
        seen = sda_line;
        scl  = 1'b0;
    endtask : clock_bit

    task automatic put_bits(input logic [7:0] b, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            clock_bit(b[i], s);
        end
    endtask : put_bits

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        put_bits(b, 8);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : put_byte

    // Reads are only ever addressed to one device, never broadcast
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(last, s);
    endtask : get_byte
endmodule : bus_master_model

// *** testbench/power_monitor_serial_slave_bench.sv ***
`timescale 1ns/10ps
// ========================================
// Self-checking bench for the serial slave port
module power_monitor_serial_slave_bench
    import pm_serial_pkg::*;
;
    logic          clock;
    logic          rst_b;
    logic          scl;
    logic          sda_drv;
    logic          sda_line;
    logic          sda_out;
    logic          sda_oe;
    logic [5:0]    straps;
    logic          reg_wr_valid;
    logic          reg_wr_ready;
    reg_write_t    reg_wr;
    reg_read_req_t reg_rd_req;
    logic [15:0]   reg_rd_data;
    logic          addr_reserved;
    logic          fast_mode;
    logic          busy;
    logic          ack;
    logic [6:0]    my_addr;
    logic          exp_rsv;
    logic [7:0]    ptr_m;
    logic [23:0]   exp_w;
    logic [23:0]   exp_q [$];
    logic [5:0]    tbl [5] = '{6'h21, 6'h38, 6'h00, 6'h1B, 6'h33};
    int            num_errors = 0;
    int            n_tests = 0;
    int            wr_seen = 0;
    int            seen0;
    int            cycles = 0;

    assign sda_line    = sda_drv & ~(sda_oe & ~sda_out);
    assign reg_rd_data = {reg_rd_req.addr, ~reg_rd_req.addr};
    assign my_addr     = {ADDR_LEAD_BIT, straps};
    assign exp_rsv     = (straps[5:4] == STRAP_CLOCK && straps[3])
                       || (straps == {STRAP_DATA, STRAP_GND, STRAP_SUPPLY});

    power_monitor_serial_slave dut_u (
        .clock            (clock),
        .rst_b            (rst_b),
        .scl_in           (scl),
        .sda_in           (sda_line),
        .sda_out          (sda_out),
        .sda_oe           (sda_oe),
        .addr_strap_pin_0 (straps[1:0]),
        .addr_strap_pin_1 (straps[3:2]),
        .addr_strap_pin_2 (straps[5:4]),
        .reg_wr_valid     (reg_wr_valid),
        .reg_wr_ready     (reg_wr_ready),
        .reg_wr           (reg_wr),
        .reg_rd_req       (reg_rd_req),
        .reg_rd_data      (reg_rd_data),
        .addr_reserved    (addr_reserved),
        .fast_mode        (fast_mode),
        .busy             (busy)
    );

    bus_master_model master_u (
        .clock    (clock),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_drv  (sda_drv)
    );

    initial clock = 1'b0;
    always #10 clock = ~clock;

    // ========================================
    // Shared tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask : settle

    task automatic do_reset(input logic [5:0] s);
        @(negedge clock);
        rst_b  = 1'b0;
        straps = s;
        settle(12);
        rst_b = 1'b1;
    endtask : do_reset

    task automatic write_word(input logic [6:0] a, input logic exp_ack, input logic end_stop);
        logic [23:0] w;
        w = 24'($urandom());
        master_u.start_cond();
        master_u.put_byte({a, DIR_WRITE}, ack);
        check(ack, exp_ack);
        for (int i = 2; i >= 0; i--) begin
            master_u.put_byte(w[i*8 +: 8], ack);
            check(ack, exp_ack);
        end
        if (exp_ack) exp_q.push_back(w);
        if (end_stop) master_u.stop_cond();
        if (end_stop) settle(20);
    endtask : write_word

    task automatic read_word(input logic with_ptr, input logic [7:0] p);
        logic [7:0] hi;
        logic [7:0] lo;
        if (with_ptr) begin
            master_u.start_cond();
            master_u.put_byte({my_addr, DIR_WRITE}, ack);
            check(ack, 1'b1);
            master_u.put_byte(p, ack);
            check(ack, 1'b1);
            ptr_m = p;
        end
        master_u.start_cond();
        master_u.put_byte({my_addr, DIR_READ}, ack);
        check(ack, 1'b1);
        master_u.get_byte(1'b0, hi);
        master_u.get_byte(1'b1, lo);
        master_u.stop_cond();
        settle(20);
        check({hi, lo}, {ptr_m, ~ptr_m});
        ptr_m = ptr_m + 8'h01;
        check(reg_rd_req, ptr_m);
        check(busy, 1'b0);
    endtask : read_word

    // ========================================
    // Write monitor: every accepted write must be the next one expected
    // Sampled on the falling edge, away from the edge that launches the pulse
    always @(negedge clock) begin
        if (rst_b && reg_wr_valid) begin
            wr_seen++;
            exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
            check(reg_wr, exp_w);
        end
    end

    // Whole run needs about 22000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            complete_run();
        end
    end

    // ========================================
    // Main sequence
    initial begin
        void'($urandom(14));
        rst_b        = 1'b0;
        reg_wr_ready = 1'b1;
        straps       = 6'h00;
        foreach (tbl[i]) begin
            do_reset(tbl[i]);
            settle(60);
            check(addr_reserved, exp_rsv);
            check(sda_oe, 1'b0);
            check(reg_rd_req, POINTER_RESET);
            ptr_m = POINTER_RESET;
            if (!exp_rsv) read_word(1'b0, 8'h00);
            write_word(my_addr, !exp_rsv, 1'b1);
            write_word(my_addr ^ 7'h01, 1'b0, 1'b1);
        end
        $display("test strap_table done");
        // Start while the power-up hold-off runs must be ignored
        do_reset(6'h33);
        write_word(my_addr, 1'b0, 1'b1);
        $display("test powerup_start done");
        read_word(1'b1, 8'(($urandom() % 250)));
        read_word(1'b1, 8'hFF);
        $display("test random_read done");
        // Stop in the middle of the upper data byte
        master_u.start_cond();
        master_u.put_byte({my_addr, DIR_WRITE}, ack);
        master_u.put_byte(8'h10, ack);
        master_u.put_bits(8'hA5, 4);
        master_u.stop_cond();
        settle(20);
        check(sda_oe, 1'b0);
        check(busy, 1'b0);
        write_word(my_addr, 1'b1, 1'b1);
        $display("test abort done");
        seen0 = wr_seen;
        write_word(my_addr, 1'b1, 1'b0);
        write_word(my_addr ^ 7'h01, 1'b0, 1'b0);
        settle(20);
        check(24'(wr_seen), 24'(seen0));
        master_u.stop_cond();
        settle(20);
        check(24'(exp_q.size()), 24'h000000);
        $display("test group done");
        master_u.start_cond();
        master_u.put_byte({HS_CODE_TOP, 3'($urandom())}, ack);
        write_word(my_addr, 1'b1, 1'b0);
        check(fast_mode, 1'b1);
        master_u.stop_cond();
        settle(20);
        check(fast_mode, 1'b0);
        $display("test fast_mode done");
        // Core stalls while two writes arrive; the buffer must keep both
        reg_wr_ready = 1'b0;
        write_word(my_addr, 1'b1, 1'b1);
        write_word(my_addr, 1'b1, 1'b1);
        check(24'(exp_q.size()), 24'h000002);
        reg_wr_ready = 1'b1;
        settle(10);
        check(24'(exp_q.size()), 24'h000000);
        $display("test stall done");
        complete_run();
    end
endmodule : power_monitor_serial_slave_bench
